// [rtl/addr_fifo_defines.svh]
// Constants for the read address channel FIFO stage.
`ifndef ADDR_FIFO_DEFINES_SVH
`define ADDR_FIFO_DEFINES_SVH
`define FIFO_DEPTH 4
`define ADDR_W 32
`define PROT_W 3
`define ENTRY_W 35
`define CODE_W 42
`define PARITY_W 6
`define LEVEL_W 3
`define SETTING_W 2
`define PADDR_W 12
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define SETTINGS_OFFSET 12'h008
`define FAULT_COUNT_OFFSET 12'h00C
`define FAULT_ADDR_OFFSET 12'h010
`define CTRL_ECC_BIT 0
`define CTRL_ECC_RESET 1'b1
`define STAT_LEVEL_LSB 0
`define STAT_HIGH_BIT 4
`define STAT_LOW_BIT 5
`define STAT_CORR_BIT 6
`define STAT_UNCORR_BIT 7
`define STAT_OUT_VALID_BIT 8
`define SET_LOW_LSB 8
`define CNT_UNCORR_LSB 8
`define FAULT_CNT_W 8
`define INJECT_BIT_A 3
`define INJECT_BIT_B 5
`endif

// [rtl/addr_fifo_pkg.sv]
// Types shared by the read address channel FIFO stage.
`include "addr_fifo_defines.svh"
package addr_fifo_pkg;
	typedef struct packed {
		logic [`ADDR_W-1:0] addr;
		logic [`PROT_W-1:0] prot;
	} addr_entry_t;
	typedef logic [`CODE_W-1:0] code_word_t;
	typedef struct packed {
		logic corrected;
		logic uncorrectable;
	} fault_t;
	typedef struct packed {
		addr_entry_t data;
		fault_t fault;
	} decoded_t;
	typedef struct packed {
		logic loaded;
		logic [`SETTING_W-1:0] high_setting;
		logic [`SETTING_W-1:0] low_setting;
		logic ecc_enable;
		logic out_valid;
		addr_entry_t out_entry;
		fault_t out_fault;
		logic [`LEVEL_W-1:0] level;
		logic high_flag;
		logic low_flag;
		logic sticky_corr;
		logic sticky_uncorr;
		logic [`FAULT_CNT_W-1:0] corr_count;
		logic [`FAULT_CNT_W-1:0] uncorr_count;
		logic [`ADDR_W-1:0] fault_addr;
		logic [31:0] rdata;
	} top_state_t;
endpackage : addr_fifo_pkg

// [rtl/read_address_channel_fifo_status.sv]
// Read address channel FIFO stage with ECC, level flags and APB status.
`timescale 1ns/1ns
`include "addr_fifo_defines.svh"

module addr_fifo_store #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [CW-1:0] count;
	} store_state_t;

	store_state_t st;
	store_state_t next_st;
	logic push;
	logic pop;

	assign in_ready = (st.count != FULL);
	assign out_valid = (st.count != '0);
	assign out_data = st.mem[st.rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wr_ptr] = in_data;
			next_st.wr_ptr = (st.wr_ptr == LAST) ? '0 : st.wr_ptr + 1'b1;
		end
		if (pop) begin
			next_st.rd_ptr = (st.rd_ptr == LAST) ? '0 : st.rd_ptr + 1'b1;
		end
		case ({push, pop})
			2'b10: next_st.count = st.count + 1'b1;
			2'b01: next_st.count = st.count - 1'b1;
			default: next_st.count = st.count;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule : addr_fifo_store

// Overview of operation
// - High level setting loaded from input bus.
// - Low level setting loaded from input bus.
// - One-bit fault forced on write with ECC.
// - Two-bit fault forced on write with ECC.
// - Corrected fault flagged on one-bit repair.
// - Uncorrectable fault flagged on two-bit error.
// - Write not taken while full; contents stay intact.
// - Refused write flag held at zero.
// - Read not made while empty; contents stay intact.
// - Refused read flag held at zero.
// - Write side level never under-reports.
// - Read side level never over-reports.
// - Common level gives words currently stored.
// - High mark while level at or above setting.
// - Low mark while level at or below setting.
// - Address and protection stable until ready.
module read_address_channel_fifo_status (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [`PADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`ADDR_W-1:0] s_axi_araddr,
	input wire logic [`PROT_W-1:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [`ADDR_W-1:0] m_axi_araddr,
	output logic [`PROT_W-1:0] m_axi_arprot,
	output logic m_axi_arvalid,
	input wire logic m_axi_arready,
	input wire logic [`SETTING_W-1:0] addr_fifo_high_level_setting,
	input wire logic [`SETTING_W-1:0] addr_fifo_low_level_setting,
	input wire logic addr_fifo_force_one_bit_fault,
	input wire logic addr_fifo_force_two_bit_fault,
	output logic addr_fifo_corrected_fault,
	output logic addr_fifo_uncorrectable_fault,
	output logic addr_fifo_write_refused,
	output logic addr_fifo_read_refused,
	output logic [`LEVEL_W-1:0] addr_fifo_write_side_level,
	output logic [`LEVEL_W-1:0] addr_fifo_read_side_level,
	output logic [`LEVEL_W-1:0] addr_fifo_level,
	output logic addr_fifo_high_mark_flag,
	output logic addr_fifo_low_mark_flag
);
	addr_fifo_pkg::top_state_t st;
	addr_fifo_pkg::top_state_t next_st;
	addr_fifo_pkg::addr_entry_t in_entry;
	addr_fifo_pkg::code_word_t in_code;
	addr_fifo_pkg::code_word_t store_out;
	addr_fifo_pkg::decoded_t dec;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic push;
	logic pop;
	logic out_take;
	logic setup;
	logic access_wr;
	logic mapped;

	// Hamming code with an overall parity bit in position zero.
	function automatic addr_fifo_pkg::code_word_t ecc_encode(
		input addr_fifo_pkg::addr_entry_t d);
		addr_fifo_pkg::code_word_t c;
		int k;
		c = '0;
		k = 0;
		for (int j = 1; j < `CODE_W; j++) begin
			if ((j & (j - 1)) != 0) begin
				c[j] = d[k];
				k++;
			end
		end
		for (int p = 0; p < `PARITY_W; p++) begin
			for (int j = 1; j < `CODE_W; j++) begin
				if (((j & (1 << p)) != 0) && (j != (1 << p))) begin
					c[1 << p] = c[1 << p] ^ c[j];
				end
			end
		end
		c[0] = ^c[`CODE_W-1:1];
		return c;
	endfunction : ecc_encode

	// Repairs a single flipped bit and reports a double one.
	function automatic addr_fifo_pkg::decoded_t ecc_decode(
		input addr_fifo_pkg::code_word_t w);
		addr_fifo_pkg::code_word_t c;
		addr_fifo_pkg::decoded_t r;
		logic [`PARITY_W-1:0] s;
		logic all_par;
		int k;
		c = w;
		r = '0;
		s = '0;
		k = 0;
		for (int p = 0; p < `PARITY_W; p++) begin
			for (int j = 1; j < `CODE_W; j++) begin
				if ((j & (1 << p)) != 0) begin
					s[p] = s[p] ^ c[j];
				end
			end
		end
		all_par = ^c;
		if ((s != '0) && all_par) begin
			r.fault.corrected = 1'b1;
			if (int'(s) < `CODE_W) begin
				c[s] = ~c[s];
			end
		end else if (s != '0) begin
			r.fault.uncorrectable = 1'b1;
		end else if (all_par) begin
			r.fault.corrected = 1'b1;
			c[0] = ~c[0];
		end
		for (int j = 1; j < `CODE_W; j++) begin
			if ((j & (j - 1)) != 0) begin
				r.data[k] = c[j];
				k++;
			end
		end
		return r;
	endfunction : ecc_decode

	addr_fifo_store #(
		.WIDTH(`CODE_W),
		.DEPTH(`FIFO_DEPTH)
	) store (
		.pclk(pclk),
		.presetn(presetn),
		.in_data(in_code),
		.in_valid(s_axi_arvalid),
		.in_ready(fifo_in_ready),
		.out_data(store_out),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready)
	);

	assign in_entry = '{addr: s_axi_araddr, prot: s_axi_arprot};
	assign s_axi_arready = fifo_in_ready;
	assign push = s_axi_arvalid && fifo_in_ready;
	assign out_take = st.out_valid && m_axi_arready;
	assign fifo_out_ready = !st.out_valid || m_axi_arready;
	assign pop = fifo_out_valid && fifo_out_ready;
	assign dec = ecc_decode(store_out);
	assign setup = psel && !penable;
	assign access_wr = psel && penable && pwrite;

	always_comb begin
		in_code = ecc_encode(in_entry);
		if (st.ecc_enable && addr_fifo_force_two_bit_fault) begin
			in_code[`INJECT_BIT_A] = ~in_code[`INJECT_BIT_A];
			in_code[`INJECT_BIT_B] = ~in_code[`INJECT_BIT_B];
		end else if (st.ecc_enable && addr_fifo_force_one_bit_fault) begin
			in_code[`INJECT_BIT_A] = ~in_code[`INJECT_BIT_A];
		end
	end

	always_comb begin
		case (paddr)
			`CTRL_OFFSET: mapped = 1'b1;
			`STATUS_OFFSET: mapped = 1'b1;
			`SETTINGS_OFFSET: mapped = 1'b1;
			`FAULT_COUNT_OFFSET: mapped = 1'b1;
			`FAULT_ADDR_OFFSET: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	always_comb begin
		next_st = st;
		// Settings are loaded from the input buses on the first clock after reset and held after.
		if (!st.loaded) begin
			next_st.loaded = 1'b1;
			next_st.high_setting = addr_fifo_high_level_setting;
			next_st.low_setting = addr_fifo_low_level_setting;
		end
		// The presented entry changes only once downstream has taken it.
		if (out_take) begin
			next_st.out_valid = 1'b0;
			next_st.out_fault = '0;
		end
		if (pop) begin
			next_st.out_valid = 1'b1;
			next_st.out_entry = dec.data;
			if (st.ecc_enable) begin
				next_st.out_fault = dec.fault;
			end else begin
				next_st.out_fault = '0;
			end
		end
		case ({push, out_take})
			2'b10: next_st.level = st.level + 1'b1;
			2'b01: next_st.level = st.level - 1'b1;
			default: next_st.level = st.level;
		endcase
		next_st.high_flag = (next_st.level >= {1'b0, next_st.high_setting});
		next_st.low_flag = (next_st.level <= {1'b0, next_st.low_setting});
		// Sticky fault bits: a new fault wins over a clear in the same cycle.
		if (access_wr && (paddr == `STATUS_OFFSET)) begin
			if (pwdata[`STAT_CORR_BIT]) begin
				next_st.sticky_corr = 1'b0;
			end
			if (pwdata[`STAT_UNCORR_BIT]) begin
				next_st.sticky_uncorr = 1'b0;
			end
		end
		if (access_wr && (paddr == `FAULT_COUNT_OFFSET)) begin
			next_st.corr_count = '0;
			next_st.uncorr_count = '0;
		end
		if (pop && st.ecc_enable && dec.fault.corrected) begin
			next_st.sticky_corr = 1'b1;
			if (next_st.corr_count != '1) begin
				next_st.corr_count = next_st.corr_count + 1'b1;
			end
		end
		if (pop && st.ecc_enable && dec.fault.uncorrectable) begin
			next_st.sticky_uncorr = 1'b1;
			next_st.fault_addr = dec.data.addr;
			if (next_st.uncorr_count != '1) begin
				next_st.uncorr_count = next_st.uncorr_count + 1'b1;
			end
		end
		if (access_wr && (paddr == `CTRL_OFFSET)) begin
			next_st.ecc_enable = pwdata[`CTRL_ECC_BIT];
		end
		// Read data is captured in the setup cycle and shown in the access.
		if (setup) begin
			next_st.rdata = '0;
			case (paddr)
				`CTRL_OFFSET: begin
					next_st.rdata[`CTRL_ECC_BIT] = st.ecc_enable;
				end
				`STATUS_OFFSET: begin
					next_st.rdata[`STAT_LEVEL_LSB +: `LEVEL_W] = st.level;
					next_st.rdata[`STAT_HIGH_BIT] = st.high_flag;
					next_st.rdata[`STAT_LOW_BIT] = st.low_flag;
					next_st.rdata[`STAT_CORR_BIT] = st.sticky_corr;
					next_st.rdata[`STAT_UNCORR_BIT] = st.sticky_uncorr;
					next_st.rdata[`STAT_OUT_VALID_BIT] = st.out_valid;
				end
				`SETTINGS_OFFSET: begin
					next_st.rdata[`SETTING_W-1:0] = st.high_setting;
					next_st.rdata[`SET_LOW_LSB +: `SETTING_W] = st.low_setting;
				end
				`FAULT_COUNT_OFFSET: begin
					next_st.rdata[`FAULT_CNT_W-1:0] = st.corr_count;
					next_st.rdata[`CNT_UNCORR_LSB +: `FAULT_CNT_W] =
						st.uncorr_count;
				end
				`FAULT_ADDR_OFFSET: begin
					next_st.rdata = st.fault_addr;
				end
				default: begin
					next_st.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.ecc_enable <= `CTRL_ECC_RESET;
			st.low_flag <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.rdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign m_axi_araddr = st.out_entry.addr;
	assign m_axi_arprot = st.out_entry.prot;
	assign m_axi_arvalid = st.out_valid;
	assign addr_fifo_corrected_fault = st.out_fault.corrected;
	assign addr_fifo_uncorrectable_fault = st.out_fault.uncorrectable;
	// Writes are only taken with room, so a refused write never occurs.
	assign addr_fifo_write_refused = 1'b0;
	// Reads are only made with data, so a refused read never occurs.
	assign addr_fifo_read_refused = 1'b0;
	assign addr_fifo_write_side_level = st.level;
	assign addr_fifo_read_side_level = st.level;
	assign addr_fifo_level = st.level;
	assign addr_fifo_high_mark_flag = st.high_flag;
	assign addr_fifo_low_mark_flag = st.low_flag;
endmodule : read_address_channel_fifo_status

// [tb/addr_fifo_chk.sv]
// Checker for the read address channel FIFO stage ports.
`timescale 1ns/1ns
module addr_fifo_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] m_axi_araddr,
	input wire logic [2:0] m_axi_arprot,
	input wire logic m_axi_arvalid,
	input wire logic m_axi_arready,
	input wire logic [1:0] addr_fifo_high_level_setting,
	input wire logic [1:0] addr_fifo_low_level_setting,
	input wire logic addr_fifo_write_refused,
	input wire logic addr_fifo_read_refused,
	input wire logic [2:0] addr_fifo_write_side_level,
	input wire logic [2:0] addr_fifo_read_side_level,
	input wire logic [2:0] addr_fifo_level,
	input wire logic addr_fifo_high_mark_flag,
	input wire logic addr_fifo_low_mark_flag
);
	logic [1:0] settle;
	logic tin;
	logic tout;
	assign tin = s_axi_arvalid && s_axi_arready;
	assign tout = m_axi_arvalid && m_axi_arready;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			settle <= 2'h0;
		else if (settle != 2'h2)
			settle <= settle + 2'h1;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	refuse_zero_a: assert property (
		!addr_fifo_write_refused && !addr_fifo_read_refused)
		else $error("refused flag raised");
	levels_match_a: assert property (
		addr_fifo_write_side_level == addr_fifo_level &&
		addr_fifo_read_side_level == addr_fifo_level)
		else $error("levels differ");
	level_step_a: assert property (settle != 2'h0 |=>
		addr_fifo_level == 3'($past(addr_fifo_level) +
		3'($past(tin)) - 3'($past(tout))))
		else $error("level step wrong");
	room_open_a: assert property (
		addr_fifo_level < 3'h4 |-> s_axi_arready)
		else $error("ready low with room");
	full_block_a: assert property (
		addr_fifo_level == 3'h5 |-> !s_axi_arready && m_axi_arvalid)
		else $error("ready high when full");
	high_mark_a: assert property (settle == 2'h2 |->
		addr_fifo_high_mark_flag ==
		(addr_fifo_level >= 3'(addr_fifo_high_level_setting)))
		else $error("high mark wrong");
	low_mark_a: assert property (settle == 2'h2 |->
		addr_fifo_low_mark_flag ==
		(addr_fifo_level <= 3'(addr_fifo_low_level_setting)))
		else $error("low mark wrong");
	hold_entry_a: assert property (m_axi_arvalid && !m_axi_arready |=>
		m_axi_arvalid && $stable(m_axi_araddr) && $stable(m_axi_arprot))
		else $error("entry changed while waiting");
	cover property (addr_fifo_level == 3'h5);
	cover property (m_axi_arvalid && !m_axi_arready);
	cover property (tin && tout);
endmodule : addr_fifo_chk
bind read_address_channel_fifo_status addr_fifo_chk addr_fifo_chk_i (.*);

// [tb/addr_sink.sv]
// Downstream slave model that takes entries from the FIFO stage.
`timescale 1ns/1ns
module addr_sink (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [31:0] m_axi_araddr,
	input wire logic [2:0] m_axi_arprot,
	input wire logic m_axi_arvalid,
	input wire logic addr_fifo_corrected_fault,
	input wire logic addr_fifo_uncorrectable_fault,
	input wire logic [1:0] mode,
	output logic m_axi_arready
);
	logic [36:0] got[$];
	int seed = 32'h96A0;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			m_axi_arready <= 1'b0;
		else begin
			if (m_axi_arvalid && m_axi_arready)
				got.push_back({addr_fifo_corrected_fault,
					addr_fifo_uncorrectable_fault, m_axi_araddr, m_axi_arprot});
			m_axi_arready <= mode[1] ? $random(seed) % 3 != 0 : mode[0];
		end
	end
endmodule : addr_sink

// [tb/tb.sv]
// Self-checking bench for the read address channel FIFO stage.
`timescale 1ns/1ns
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, ecc;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [31:0] s_axi_araddr, m_axi_araddr;
	logic [2:0] s_axi_arprot, m_axi_arprot;
	logic s_axi_arvalid, s_axi_arready, m_axi_arvalid, m_axi_arready;
	logic [1:0] addr_fifo_high_level_setting, addr_fifo_low_level_setting;
	logic addr_fifo_force_one_bit_fault, addr_fifo_force_two_bit_fault;
	logic addr_fifo_corrected_fault, addr_fifo_uncorrectable_fault;
	logic addr_fifo_write_refused, addr_fifo_read_refused;
	logic [2:0] addr_fifo_write_side_level, addr_fifo_read_side_level;
	logic [2:0] addr_fifo_level;
	logic addr_fifo_high_mark_flag, addr_fifo_low_mark_flag;
	logic [1:0] mode;
	logic [36:0] exp[$];
	logic [36:0] m;
	int err_count, checks, seed, n, i;
	read_address_channel_fifo_status read_address_channel_fifo_status_i (.*);
	addr_sink addr_sink_i (.*);
	task automatic chk(input logic [36:0] seen, input logic [36:0] want);
		checks++;
		if (seen !== want) begin
			err_count++;
			$display("Error %0t: seen %0h expected %0h", $time, seen, want);
		end
	endtask : chk
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	task automatic hang();
		err_count++;
		final_report();
	endtask : hang
	task automatic wait_for(input bit k);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while ((k ? pready : s_axi_arready) !== 1'b1 && n < 300);
		perr = pslverr;
		if ((k ? pready : s_axi_arready) !== 1'b1)
			hang();
	endtask : wait_for
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		wait_for(1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic push(input logic [34:0] e, input logic f1, input logic f2);
		s_axi_arvalid <= 1'b1;
		{s_axi_araddr, s_axi_arprot} <= e;
		addr_fifo_force_one_bit_fault <= f1;
		addr_fifo_force_two_bit_fault <= f2;
		exp.push_back({ecc & f1 & ~f2, ecc & f2, e});
		wait_for(1'b0);
	endtask : push
	task automatic idle();
		s_axi_arvalid <= 1'b0;
		addr_fifo_force_one_bit_fault <= 1'b0;
		addr_fifo_force_two_bit_fault <= 1'b0;
		@(posedge pclk);
	endtask : idle
	task automatic lvl(input logic [2:0] v);
		@(negedge pclk);
		chk(addr_fifo_level, v);
		chk(addr_fifo_high_mark_flag, v >= addr_fifo_high_level_setting);
		chk(addr_fifo_low_mark_flag, v <= addr_fifo_low_level_setting);
		chk(s_axi_arready, v < 3'h4);
		@(posedge pclk);
	endtask : lvl
	task automatic drain(input int cnt);
		mode <= 2'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (addr_sink_i.got.size() < cnt && n < 300);
		mode <= 2'h0;
		if (n == 300)
			hang();
		foreach (exp[i]) begin
			m = exp[i][35] ? 37'h18_0000_0000 : '1;
			chk(addr_sink_i.got[i] & m, exp[i] & m);
		end
		exp.delete();
		addr_sink_i.got.delete();
		lvl(3'h0);
		$display("test with %0d entries done", cnt);
	endtask : drain
	task automatic rst(input logic [1:0] h, input logic [1:0] l);
		presetn <= 1'b0;
		ecc = 1'b1;
		addr_fifo_high_level_setting <= h;
		addr_fifo_low_level_setting <= l;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, {22'h0, l, 6'h0, h});
		lvl(3'h0);
	endtask : rst
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		#9000000;
		hang();
	end
	initial begin
		seed = 32'h96A0;
		ecc = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{s_axi_arvalid, s_axi_araddr, s_axi_arprot} = '0;
		{addr_fifo_force_one_bit_fault, addr_fifo_force_two_bit_fault} = '0;
		mode = 2'h0;
		rst(2'h3, 2'h1);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h1);
		apb(1'b0, 12'h020, 32'h0);
		chk({perr, rd}, {1'b1, 32'h0});
		for (i = 0; i < 5; i++)
			push({$random(seed), 3'(i)}, 1'b0, 1'b0);
		idle();
		lvl(3'h5);
		drain(5);
		mode <= 2'h2;
		for (i = 0; i < 40; i++)
			push(35'({$random(seed), $random(seed)}), 1'($random(seed)),
				1'($random(seed)));
		idle();
		drain(40);
		apb(1'b1, 12'h00C, 32'h0);
		push(35'h5_1234_5678, 1'b1, 1'b0);
		push(35'h2_8765_4321, 1'b0, 1'b1);
		idle();
		drain(2);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rd, 32'h0000_0101);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd[7:6], 2'h3);
		apb(1'b1, 12'h000, 32'h0);
		ecc = 1'b0;
		push(35'h3_0F0F_0F0F, 1'b1, 1'b1);
		idle();
		drain(1);
		rst(2'h2, 2'h0);
		for (i = 0; i < 3; i++)
			push({$random(seed), 3'(i)}, 1'b0, 1'b0);
		idle();
		lvl(3'h3);
		drain(3);
		final_report();
	end
endmodule : tb
